/* rtl/aam_top.sv */
// aux address modifier: pointer, block size, index and stack registers,
// one-cycle address generation for decode, Avalon-MM register slave
// assumes decode runs on the same clock; requests need no synchroniser
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.

// How it works
// [RQ1] circular length uses only block_size_reg low 16 bits and chosen pointer
// [RQ2] N is the highest set bit of block_size_reg low half
// [RQ3] base keeps pointer bits 31..N+1, bits N..0 are zero
// [RQ4] index is pointer low bits; step is a signed add or subtract
// [RQ5] index plus step inside zero..block size is kept as is
// [RQ6] index plus step at or above block size subtracts block size
// [RQ7] negative index plus step adds block size
// [RQ8] software never steps further than the block size
// [RQ9] pointer lies inside the buffer before first circular access
// [RQ10] software loads index_reg_zero with half the transform size
// [RQ11] bit-reversed add carries from msb toward lsb
// [RQ12] successive bit-reversed steps give mirrored step count in low bits
// [RQ13] stack_pointer is a 32-bit register addressing the top element
// [RQ14] system stack grows toward higher addresses
// [RQ15] push increments then stores; pop reads then decrements
// [RQ16] after push or pop the pointer addresses the top element
// [RQ17] program_counter moves through the stack on calls, traps, returns
// [RQ18] integer and float push and pop use the same discipline
// [RQ19] aux pointers allow pre and post increment and decrement
// [RQ20] pre-modify uses new pointer; post-modify uses old pointer
// [RQ21] circular write-back keeps bits above index, replaces index
// [RQ22] circular and bit-reversed updates finish in the address cycle
module aam_top
	import aam_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        ce,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// request from decode
	input  wire logic        req_valid,
	input  wire aam_op_t     req_op,
	input  wire aam_mod_t    req_mod,
	input  wire logic [2:0]  req_ar,
	input  wire logic [31:0] req_step,
	input  wire aam_src_t    req_src,
	// answer to operand fetch
	output logic             acc_valid,
	output logic      [31:0] acc_addr,
	output logic      [31:0] acc_ptr,
	output aam_src_t         acc_src
);

	// state
	logic [31:0] aux_r [8];
	logic [31:0] aux_nxt [8];
	logic [31:0] blk_size_r, blk_size_nxt;
	logic [31:0] idx0_r, idx0_nxt;
	logic [31:0] idx1_r, idx1_nxt;
	logic [31:0] stk_ptr_r, stk_ptr_nxt;
	logic [31:0] last_r, last_nxt;
	logic        valid_r, valid_nxt;
	logic [31:0] addr_r, addr_nxt;
	logic [31:0] ptr_r, ptr_nxt;
	aam_src_t    src_r, src_nxt;
	logic        wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	// datapath
	logic [31:0] cur;
	logic [31:0] circ_step;
	logic [31:0] circ_new;
	logic [31:0] circ_mask;
	logic [31:0] brev_new;
	logic [31:0] mod_new;
	logic [31:0] mod_addr;
	logic        bus_commit;

	// mirror a word end for end
	function automatic logic [31:0] rev32(input logic [31:0] v);
		logic [31:0] r;
		r = 32'h0000_0000;
		for (int i = 0; i < 32; i++) begin
			r[i] = v[31 - i];
		end
		return r;
	endfunction

	// merge write data by byte lane
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return r;
	endfunction

	// selected pointer and signed circular step
	assign cur       = aux_r[req_ar];
	assign circ_step = (req_mod == AAM_MOD_CIRC_SUB) ? (32'h0 - req_step)
		: req_step; // RQ4

	aam_circ aam_circ_i (
		.ptr      (cur),
		.blk_size (blk_size_r[AAM_BLK_W-1:0]), // RQ1 RQ2
		.step     (circ_step),
		.nxt      (circ_new), // RQ3 RQ5 RQ6 RQ7
		.mask     (circ_mask)
	);

	// reverse-carry add: mirror, add, mirror back
	assign brev_new = rev32(rev32(cur) + rev32(idx0_r)); // RQ11 RQ12

	// new pointer and address for an aux access
	always_comb begin
		mod_new  = cur;
		mod_addr = cur;
		unique case (req_mod)
			AAM_MOD_PRE_ADD: begin
				mod_new  = cur + req_step; // RQ19
				mod_addr = mod_new; // RQ20
			end
			AAM_MOD_PRE_SUB: begin
				mod_new  = cur - req_step; // RQ19
				mod_addr = mod_new; // RQ20
			end
			AAM_MOD_POST_ADD: begin
				mod_new  = cur + req_step; // RQ19
				mod_addr = cur; // RQ20
			end
			AAM_MOD_POST_SUB: begin
				mod_new  = cur - req_step; // RQ19
				mod_addr = cur; // RQ20
			end
			AAM_MOD_CIRC_ADD, AAM_MOD_CIRC_SUB: begin
				mod_new  = circ_new; // RQ21
				mod_addr = cur;
			end
			AAM_MOD_BITREV: begin
				mod_new  = brev_new; // RQ11
				mod_addr = cur;
			end
			default: begin
				mod_new  = cur;
				mod_addr = cur;
			end
		endcase
	end

	// bus write lands at the edge where waitrequest is seen low
	assign bus_commit = avs_write && !wait_r;

	// register file and answer: decode first, a bus write overrides
	always_comb begin
		for (int k = 0; k < 8; k++) begin
			aux_nxt[k] = aux_r[k];
		end
		blk_size_nxt = blk_size_r;
		idx0_nxt     = idx0_r;
		idx1_nxt     = idx1_r;
		stk_ptr_nxt  = stk_ptr_r;
		last_nxt  = last_r;
		valid_nxt = req_valid; // RQ22
		addr_nxt  = addr_r;
		ptr_nxt   = ptr_r;
		src_nxt   = req_valid ? req_src : src_r;
		if (req_valid) begin
			unique case (req_op)
				AAM_OP_PUSH: begin
					stk_ptr_nxt = stk_ptr_r + AAM_STK_STEP; // RQ14 RQ15
					addr_nxt    = stk_ptr_nxt; // RQ15 RQ17 RQ18
					ptr_nxt     = stk_ptr_nxt; // RQ16
				end
				AAM_OP_POP: begin
					addr_nxt    = stk_ptr_r; // RQ15 RQ17 RQ18
					stk_ptr_nxt = stk_ptr_r - AAM_STK_STEP; // RQ15
					ptr_nxt     = stk_ptr_nxt; // RQ16
				end
				AAM_OP_AUX: begin
					aux_nxt[req_ar] = mod_new; // RQ22
					addr_nxt        = mod_addr;
					ptr_nxt         = mod_new;
				end
				default: begin
					addr_nxt = addr_r;
				end
			endcase
			last_nxt = addr_nxt;
		end
		if (bus_commit) begin
			if (avs_address <= AAM_OFF_AUX7) begin
				aux_nxt[avs_address[AAM_AUX_SEL_LSB +: 3]] = merge(
					aux_r[avs_address[AAM_AUX_SEL_LSB +: 3]],
					avs_writedata, avs_byteenable);
			end else if (avs_address == AAM_OFF_BLK_SIZE) begin
				blk_size_nxt = merge(blk_size_r, avs_writedata,
					avs_byteenable);
			end else if (avs_address == AAM_OFF_IDX0) begin
				idx0_nxt = merge(idx0_r, avs_writedata, avs_byteenable);
			end else if (avs_address == AAM_OFF_IDX1) begin
				idx1_nxt = merge(idx1_r, avs_writedata, avs_byteenable);
			end else if (avs_address == AAM_OFF_STK_PTR) begin
				stk_ptr_nxt = merge(stk_ptr_r, avs_writedata,
					avs_byteenable); // RQ13
			end
		end
	end

	// slave handshake: one wait cycle, then a single-cycle answer
	always_comb begin
		wait_nxt  = 1'b1;
		rdata_nxt = rdata_r;
		if (wait_r && (avs_read || avs_write)) begin
			wait_nxt  = 1'b0;
			rdata_nxt = 32'h0000_0000;
			if (avs_address <= AAM_OFF_AUX7) begin
				rdata_nxt = aux_r[avs_address[AAM_AUX_SEL_LSB +: 3]];
			end else if (avs_address == AAM_OFF_BLK_SIZE) begin
				rdata_nxt = blk_size_r;
			end else if (avs_address == AAM_OFF_IDX0) begin
				rdata_nxt = idx0_r;
			end else if (avs_address == AAM_OFF_IDX1) begin
				rdata_nxt = idx1_r;
			end else if (avs_address == AAM_OFF_STK_PTR) begin
				rdata_nxt = stk_ptr_r;
			end else if (avs_address == AAM_OFF_LAST) begin
				rdata_nxt = last_r;
			end
		end
	end

	// register everything; clock enable freezes all state
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			for (int k = 0; k < 8; k++) begin
				aux_r[k] <= AAM_PTR_RST;
			end
			blk_size_r <= AAM_BLK_RST;
			idx0_r     <= AAM_PTR_RST;
			idx1_r     <= AAM_PTR_RST;
			stk_ptr_r  <= AAM_STK_RST;
			last_r  <= AAM_PTR_RST;
			valid_r <= 1'b0;
			addr_r  <= AAM_PTR_RST;
			ptr_r   <= AAM_PTR_RST;
			src_r   <= AAM_SRC_PROG;
			wait_r  <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else if (ce) begin
			aux_r   <= aux_nxt;
			blk_size_r <= blk_size_nxt;
			idx0_r     <= idx0_nxt;
			idx1_r     <= idx1_nxt;
			stk_ptr_r  <= stk_ptr_nxt;
			last_r  <= last_nxt;
			valid_r <= valid_nxt;
			addr_r  <= addr_nxt;
			ptr_r   <= ptr_nxt;
			src_r   <= src_nxt;
			wait_r  <= wait_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// outputs straight from flip-flops
	assign acc_valid       = valid_r;
	assign acc_addr        = addr_r;
	assign acc_ptr         = ptr_r;
	assign acc_src         = src_r;
	assign avs_readdata    = rdata_r;
	assign avs_waitrequest = wait_r;

	// checks; stack checks exclude a bus write in their antecedents so decode owns the stack pointer
	stack_push_a: assert property (@(posedge clock) disable iff (!rstn) // RQ15
		ce && req_valid && req_op == AAM_OP_PUSH && !bus_commit |=>
		stk_ptr_r == $past(stk_ptr_r) + 32'h0000_0001
		&& acc_addr == stk_ptr_r)
		else $error("push did not preincrement the stack pointer");

	stack_pop_a: assert property (@(posedge clock) disable iff (!rstn) // RQ15
		ce && req_valid && req_op == AAM_OP_POP && !bus_commit |=>
		acc_addr == $past(stk_ptr_r)
		&& stk_ptr_r == $past(stk_ptr_r) - 32'h0000_0001)
		else $error("pop did not read then decrement");

	stack_top_a: assert property (@(posedge clock) disable iff (!rstn) // RQ16
		ce && req_valid && req_op != AAM_OP_AUX && !bus_commit |=>
		acc_ptr == stk_ptr_r)
		else $error("stack pointer misreported after push or pop");

	pre_mod_a: assert property (@(posedge clock) disable iff (!rstn) // RQ20
		ce && req_valid && req_op == AAM_OP_AUX
		&& req_mod == AAM_MOD_PRE_ADD |=>
		acc_addr == acc_ptr && acc_ptr == $past(cur) + $past(req_step))
		else $error("pre-increment address is not the new pointer");

	post_mod_a: assert property (@(posedge clock) disable iff (!rstn) // RQ20
		ce && req_valid && req_op == AAM_OP_AUX
		&& req_mod == AAM_MOD_POST_SUB |=>
		acc_addr == $past(cur) && acc_ptr == $past(cur) - $past(req_step))
		else $error("post-decrement address is not the old pointer");

	circ_keep_a: assert property (@(posedge clock) disable iff (!rstn) // RQ21
		ce && req_valid && req_op == AAM_OP_AUX
		&& (req_mod == AAM_MOD_CIRC_ADD || req_mod == AAM_MOD_CIRC_SUB) |=>
		((acc_ptr ^ acc_addr) & ~$past(circ_mask)) == 32'h0000_0000)
		else $error("circular update touched bits above the index");

	circ_bound_a: assert property (@(posedge clock) disable iff (!rstn) // RQ5
		ce && req_valid && req_op == AAM_OP_AUX
		&& req_mod == AAM_MOD_CIRC_ADD
		&& (cur & circ_mask) < {16'h0000, blk_size_r[15:0]}
		&& req_step <= {16'h0000, blk_size_r[15:0]} |=>
		(acc_ptr & $past(circ_mask))
		< {16'h0000, $past(blk_size_r[15:0])})
		else $error("circular index left the buffer");

	addr_cycle_a: assert property (@(posedge clock) disable iff (!rstn) // RQ22
		ce && req_valid |=> acc_valid)
		else $error("address not produced in the next cycle");

	bus_pulse_a: assert property (@(posedge clock) disable iff (!rstn)
		ce && !avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

endmodule

/* rtl/aam_pkg.sv */
// aux address modifier: shared constants, register map and command types
// assumes one 25 MHz clock and an Avalon-MM host for the register file
package aam_pkg;

	// register map, byte addresses on the Avalon-MM slave
	localparam logic [7:0] AAM_OFF_AUX0     = 8'h00; // aux_pointer n at +4n
	localparam logic [7:0] AAM_OFF_AUX7     = 8'h1C;
	localparam logic [7:0] AAM_OFF_BLK_SIZE = 8'h20; // block_size_reg
	localparam logic [7:0] AAM_OFF_IDX0     = 8'h24; // index_reg_zero
	localparam logic [7:0] AAM_OFF_IDX1     = 8'h28; // index register one
	localparam logic [7:0] AAM_OFF_STK_PTR  = 8'h2C; // stack_pointer
	localparam logic [7:0] AAM_OFF_LAST     = 8'h30; // last address, read only

	// field layout
	localparam int AAM_AUX_SEL_LSB = 2;  // aux index sits in address [4:2]
	localparam int AAM_BLK_W       = 16; // only low half of block size used

	// values after reset
	localparam logic [31:0] AAM_PTR_RST = 32'h0000_0000;
	localparam logic [31:0] AAM_BLK_RST = 32'h0000_0000;
	localparam logic [31:0] AAM_STK_RST = 32'h0000_0000;

	// stack step and bus answer latency in cycles
	localparam logic [31:0] AAM_STK_STEP  = 32'h0000_0001;
	localparam int          AAM_BUS_LAT   = 1;

	// kind of access requested by decode
	typedef enum logic [1:0] {
		AAM_OP_AUX,
		AAM_OP_PUSH,
		AAM_OP_POP
	} aam_op_t;

	// modification of an aux_pointer
	typedef enum logic [2:0] {
		AAM_MOD_PRE_ADD,
		AAM_MOD_PRE_SUB,
		AAM_MOD_POST_ADD,
		AAM_MOD_POST_SUB,
		AAM_MOD_CIRC_ADD,
		AAM_MOD_CIRC_SUB,
		AAM_MOD_BITREV
	} aam_mod_t;

	// what a stack transfer carries
	typedef enum logic [1:0] {
		AAM_SRC_PROG, // program_counter
		AAM_SRC_INT,
		AAM_SRC_FLOAT
	} aam_src_t;

endpackage

/* rtl/aam_circ.sv */
// aux address modifier: circular buffer pointer update
// purely combinational; the caller registers the result
module aam_circ
	import aam_pkg::*;
(
	input  wire logic [31:0]          ptr,
	input  wire logic [AAM_BLK_W-1:0] blk_size,
	input  wire logic [31:0]          step,
	output logic      [31:0]          nxt,
	output logic      [31:0]          mask
);

	logic [4:0]  n;
	logic [31:0] idx;
	logic [32:0] sum;
	logic [32:0] res;

	// locate top set bit, wrap index by one block size
	always_comb begin
		n = 5'h00;
		for (int i = 0; i < AAM_BLK_W; i++) begin
			if (blk_size[i]) begin
				n = 5'(i); // RQ2
			end
		end
		mask = (32'h0000_0002 << n) - 32'h0000_0001;
		idx  = ptr & mask; // RQ4
		sum  = {1'b0, idx} + {step[31], step}; // RQ4
		if (sum[32]) begin
			res = sum + {17'h0_0000, blk_size}; // RQ7
		end else if (sum >= {17'h0_0000, blk_size}) begin
			res = sum - {17'h0_0000, blk_size}; // RQ6
		end else begin
			res = sum; // RQ5
		end
		nxt = (ptr & ~mask) | (res[31:0] & mask); // RQ3 RQ21
	end

endmodule

/* bench/aam_dec_model.sv */
// decode stage model: issues one request, collects the answer
// assumes the answer lands exactly one edge after the request
module aam_dec_model
	import aam_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        acc_valid,
	input  wire logic [31:0] acc_addr,
	input  wire logic [31:0] acc_ptr,
	input  wire aam_src_t    acc_src,
	output logic             req_valid,
	output aam_op_t          req_op,
	output aam_mod_t         req_mod,
	output logic      [2:0]  req_ar,
	output logic      [31:0] req_step,
	output aam_src_t         req_src
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle values at time zero
	initial begin
		req_valid = 1'b0;
		req_op = AAM_OP_AUX;
		req_mod = AAM_MOD_PRE_ADD;
		req_ar = 3'h0;
		req_step = 32'h0000_0000;
		req_src = AAM_SRC_PROG;
	end

	// one-cycle request, answer sampled while it stands
	task automatic issue(input aam_op_t op, input aam_mod_t md,
		input logic [2:0] ar, input logic [31:0] st, input aam_src_t sr,
		output logic v, output logic [31:0] a, output logic [31:0] p,
		output aam_src_t s);
		@(posedge clock);
		req_valid <= 1'b1;
		req_op <= op;
		req_mod <= md;
		req_ar <= ar;
		req_step <= st;
		req_src <= sr;
		@(posedge clock);
		req_valid <= 1'b0;
		req_step <= ~st; // released step no longer shows the old value
		@(negedge clock);
		v = acc_valid;
		a = acc_addr;
		p = acc_ptr;
		s = acc_src;
	endtask
endmodule

/* bench/aam_top_tb.sv */
// bench for the aux address modifier: bus preload, table of accesses,
// then clock-enable, byte-lane, read-back, unmapped and reset checks
// assumes the decode model file is compiled before this one
module aam_top_tb;
	import aam_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct {
		aam_op_t     op;
		aam_mod_t    md;
		logic [2:0]  ar;
		logic [31:0] st;
		aam_src_t    sr;
		logic [31:0] ea;
		logic [31:0] ep;
	} aam_row_t;

	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'hF;
	logic        ce = 1'b1;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        req_valid;
	aam_op_t     req_op;
	aam_mod_t    req_mod;
	logic [2:0]  req_ar;
	logic [31:0] req_step;
	aam_src_t    req_src;
	logic        acc_valid;
	logic [31:0] acc_addr;
	logic [31:0] acc_ptr;
	aam_src_t    acc_src;
	int          err_count = 0;
	int          check_count = 0;
	logic        v;
	logic [31:0] a;
	logic [31:0] p;
	logic [31:0] q;
	aam_src_t    s;

	// circular on aux1 (block 6), bit-reversed on aux2, pre and post modify on aux3, system stack
	aam_row_t rows [15] = '{
		'{AAM_OP_AUX, AAM_MOD_CIRC_ADD, 3'h1, 32'h3, AAM_SRC_INT,
			32'hF000_0108, 32'hF000_010B},
		'{AAM_OP_AUX, AAM_MOD_CIRC_ADD, 3'h1, 32'h5, AAM_SRC_INT,
			32'hF000_010B, 32'hF000_010A},
		'{AAM_OP_AUX, AAM_MOD_CIRC_SUB, 3'h1, 32'h4, AAM_SRC_INT,
			32'hF000_010A, 32'hF000_010C},
		'{AAM_OP_AUX, AAM_MOD_CIRC_ADD, 3'h1, 32'h2, AAM_SRC_INT,
			32'hF000_010C, 32'hF000_0108},
		'{AAM_OP_AUX, AAM_MOD_BITREV, 3'h2, 32'h0, AAM_SRC_INT,
			32'h60, 32'h68},
		'{AAM_OP_AUX, AAM_MOD_BITREV, 3'h2, 32'h0, AAM_SRC_INT,
			32'h68, 32'h64},
		'{AAM_OP_AUX, AAM_MOD_BITREV, 3'h2, 32'h0, AAM_SRC_INT,
			32'h64, 32'h6C},
		'{AAM_OP_AUX, AAM_MOD_PRE_ADD, 3'h3, 32'h1, AAM_SRC_INT,
			32'h1001, 32'h1001},
		'{AAM_OP_AUX, AAM_MOD_POST_SUB, 3'h3, 32'h1, AAM_SRC_INT,
			32'h1001, 32'h1000},
		'{AAM_OP_AUX, AAM_MOD_POST_ADD, 3'h3, 32'h1, AAM_SRC_INT,
			32'h1000, 32'h1001},
		'{AAM_OP_AUX, AAM_MOD_PRE_SUB, 3'h3, 32'h1, AAM_SRC_INT,
			32'h1000, 32'h1000},
		'{AAM_OP_PUSH, AAM_MOD_PRE_ADD, 3'h0, 32'h0, AAM_SRC_PROG,
			32'h201, 32'h201},
		'{AAM_OP_PUSH, AAM_MOD_PRE_ADD, 3'h0, 32'h0, AAM_SRC_INT,
			32'h202, 32'h202},
		'{AAM_OP_POP, AAM_MOD_PRE_ADD, 3'h0, 32'h0, AAM_SRC_FLOAT,
			32'h202, 32'h201},
		'{AAM_OP_POP, AAM_MOD_PRE_ADD, 3'h0, 32'h0, AAM_SRC_PROG,
			32'h201, 32'h200}
	};

	aam_top aam_top_i (
		.clock(clock), .rstn(rstn), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .req_valid(req_valid),
		.req_op(req_op), .req_mod(req_mod), .req_ar(req_ar),
		.req_step(req_step), .req_src(req_src), .acc_valid(acc_valid),
		.acc_addr(acc_addr), .acc_ptr(acc_ptr), .acc_src(acc_src)
	);

	aam_dec_model aam_dec_model_i (
		.clock(clock), .acc_valid(acc_valid), .acc_addr(acc_addr),
		.acc_ptr(acc_ptr), .acc_src(acc_src), .req_valid(req_valid),
		.req_op(req_op), .req_mod(req_mod), .req_ar(req_ar),
		.req_step(req_step), .req_src(req_src)
	);

	// 25 MHz clock
	always #20 clock = ~clock;

	task automatic final_report();
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one Avalon access held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] ad,
		input logic [31:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clock);
		avs_address <= ad;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		// waitrequest and read data are taken at the rising edge itself
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		if (avs_waitrequest !== 1'b0) begin
			err_count++;
			final_report();
		end else begin
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			avs_writedata <= ~d;
		end
	endtask

	initial begin
		@(negedge clock);
		check("wait_in_reset", {31'h0, avs_waitrequest}, 32'h1);
		check("valid_in_reset", {31'h0, acc_valid}, 32'h0);
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		bus(1'b0, AAM_OFF_STK_PTR, 32'h0, q);
		check("stk_reset", q, AAM_STK_RST);
		// upper half of block size must be ignored
		bus(1'b1, AAM_OFF_BLK_SIZE, 32'hFFFF_0006, q);
		bus(1'b1, 8'h04, 32'hF000_0108, q);
		bus(1'b1, 8'h08, 32'h0000_0060, q);
		bus(1'b1, AAM_OFF_IDX0, 32'h0000_0008, q);
		bus(1'b1, 8'h0C, 32'h0000_1000, q);
		bus(1'b1, AAM_OFF_STK_PTR, 32'h0000_0200, q);
		foreach (rows[i]) begin
			aam_dec_model_i.issue(rows[i].op, rows[i].md, rows[i].ar,
				rows[i].st, rows[i].sr, v, a, p, s);
			check("acc_valid", {31'h0, v}, 32'h1);
			check("acc_addr", a, rows[i].ea);
			check("acc_ptr", p, rows[i].ep);
			check("acc_src", {30'h0, s}, {30'h0, rows[i].sr});
		end
		// clock enable low: a push must leave every register alone
		@(posedge clock);
		ce <= 1'b0;
		aam_dec_model_i.issue(AAM_OP_PUSH, AAM_MOD_PRE_ADD, 3'h0, 32'h0,
			AAM_SRC_INT, v, a, p, s);
		check("frozen_valid", {31'h0, v}, 32'h0);
		check("frozen_addr", a, 32'h0000_0201);
		check("frozen_ptr", p, 32'h0000_0200);
		@(posedge clock);
		ce <= 1'b1;
		// only the two low byte lanes are written
		avs_byteenable <= 4'h3;
		bus(1'b1, AAM_OFF_IDX1, 32'hAABB_CCDD, q);
		avs_byteenable <= 4'hF;
		bus(1'b0, AAM_OFF_IDX1, 32'h0, q);
		check("lane_merge", q, 32'h0000_CCDD);
		// last address holds the final pop and ignores writes
		bus(1'b1, AAM_OFF_LAST, 32'h1234_5678, q);
		bus(1'b0, AAM_OFF_LAST, 32'h0, q);
		check("last_addr", q, 32'h0000_0201);
		bus(1'b0, 8'h04, 32'h0, q);
		check("aux1_back", q, 32'hF000_0108);
		bus(1'b0, AAM_OFF_STK_PTR, 32'h0, q);
		check("stk_back", q, 32'h0000_0200);
		bus(1'b0, 8'h40, 32'h0, q);
		check("unmapped", q, 32'h0);
		// reset in mid-run returns outputs and registers to idle
		@(posedge clock);
		rstn <= 1'b0;
		@(negedge clock);
		check("rst_wait", {31'h0, avs_waitrequest}, 32'h1);
		check("rst_valid", {31'h0, acc_valid}, 32'h0);
		check("rst_addr", acc_addr, AAM_PTR_RST);
		check("rst_ptr", acc_ptr, AAM_PTR_RST);
		check("rst_src", {30'h0, acc_src}, {30'h0, AAM_SRC_PROG});
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		bus(1'b0, AAM_OFF_STK_PTR, 32'h0, q);
		check("stk_after_rst", q, AAM_STK_RST);
		bus(1'b0, 8'h04, 32'h0, q);
		check("aux1_after_rst", q, AAM_PTR_RST);
		final_report();
	end
endmodule
